// *** logic/mac_arming.sv ***
// How it works
// R1 - Armed mode waits for a start edge
// R2 - Start and stop source each selectable
// R3 - Each edge rising or falling
// R4 - Start delay 20 ns to 2 s
// R5 - Only first averaging sample waits
// R6 - Start arming refused for burst/ratio/volt
// R7 - Stop arming refused also for rise/fall
// R8 - Stop edge ends running acquisition
// R9 - Stop delay extends measurement past edge
// R10 - Stop delay only with totalize
// R11 - Armed burst uses plain frequency mode
// R12 - Interval stop triggers held off
// R13 - Start accepted up to 60 ns early
// R14 - Delay counter qualifies enable, restart clears
`timescale 1ns/1ps
`default_nettype none
module mac_arming
    import mac_pkg::*;
#(
    parameter int DLY_W = 28
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_a,
    input wire logic in_b,
    input wire logic in_e,
    output logic meas_enable,
    output logic burst_self_sync,
    output logic stop_trig_block,
    output logic config_error
);
    localparam logic [DLY_W-1:0] STEPS_PER_CLK = DLY_W'(CLK_PERIOD_NS / DLY_STEP_NS);
    localparam logic [DLY_W-1:0] EARLY = DLY_W'(EARLY_STEPS);

    logic [31:0] ctrl;
    logic [DLY_W-1:0] start_dly;
    logic [DLY_W-1:0] stop_dly;
    logic [DLY_W-1:0] cnt;
    logic first_done;
    mac_state_t state;
    logic restart;
    logic sample_done;
    logic start_lvl;
    logic start_edge;
    logic stop_lvl;
    logic stop_edge;
    logic tick;
    logic [3:0] func;
    logic start_ok;
    logic stop_ok;
    logic arm_en;
    logic stop_en;
    logic wr;
    logic rd;
    logic bad_addr;

    ////////////////////////////////////////////////////////////////////////
    assign func = ctrl[CTRL_FUNC +: 4];
    assign start_ok = !(func == FN_BURST || func == FN_RATIO || func == FN_VOLT); // R6
    assign stop_ok = start_ok && (func != FN_RISEFALL); // R7
    assign arm_en = ctrl[CTRL_ARM_EN] && start_ok;
    assign stop_en = ctrl[CTRL_STOP_EN] && stop_ok;

    mac_edge_sel u_start (
        .pclk(pclk),
        .presetn(presetn),
        .in_a(in_a),
        .in_b(in_b),
        .in_e(in_e),
        .src(ctrl[CTRL_START_SRC +: 2]), // R2
        .falling(ctrl[CTRL_START_FALL]), // R3
        .level(start_lvl),
        .edge_seen(start_edge)
    );
    mac_edge_sel u_stop (
        .pclk(pclk),
        .presetn(presetn),
        .in_a(in_a),
        .in_b(in_b),
        .in_e(in_e),
        .src(ctrl[CTRL_STOP_SRC +: 2]), // R2
        .falling(ctrl[CTRL_STOP_FALL]), // R3
        .level(stop_lvl),
        .edge_seen(stop_edge)
    );
    mac_tick_div #(
        .STEPS_PER_CLK(CLK_PERIOD_NS / DLY_STEP_NS)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clear(restart),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign bad_addr = !(paddr == OFS_CTRL || paddr == OFS_START_DLY || paddr == OFS_STOP_DLY
        || paddr == OFS_STATUS || paddr == OFS_CMD);
    assign restart = wr && paddr == OFS_CMD && pwdata[CMD_RESTART];
    assign sample_done = wr && paddr == OFS_CMD && pwdata[CMD_SAMPLE_DONE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl <= pwdata;
        end
    end

    // Out-of-range delays are clamped, not refused, so software always gets a valid one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_dly <= '0;
        end else if (wr && paddr == OFS_START_DLY) begin
            if (pwdata[DLY_W-1:0] == '0) begin
                start_dly <= '0;
            end else if (pwdata[DLY_W-1:0] < DLY_MIN_STEPS) begin // R4
                start_dly <= DLY_MIN_STEPS;
            end else if (pwdata[DLY_W-1:0] > DLY_MAX_STEPS) begin // R4
                start_dly <= DLY_MAX_STEPS;
            end else begin
                start_dly <= pwdata[DLY_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_dly <= '0;
        end else if (wr && paddr == OFS_STOP_DLY) begin
            stop_dly <= pwdata[DLY_W-1:0] > DLY_MAX_STEPS ? DLY_MAX_STEPS : pwdata[DLY_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
            prdata <= 32'h0000_0000;
            if (rd && !penable) begin
                case (paddr)
                    OFS_CTRL: prdata <= ctrl;
                    OFS_START_DLY: prdata <= 32'(start_dly);
                    OFS_STOP_DLY: prdata <= 32'(stop_dly);
                    OFS_STATUS: prdata <= {26'h0, first_done, meas_enable, 1'b0, 3'(state)};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arming sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MAC_IDLE;
            cnt <= '0;
            first_done <= 1'b0;
        end else if (restart) begin // R14
            state <= MAC_IDLE;
            cnt <= '0;
            first_done <= 1'b0;
        end else begin
            case (state)
                MAC_IDLE: begin
                    if (!arm_en || first_done) begin // R5
                        state <= MAC_RUN;
                    end else begin
                        state <= MAC_WAIT_ARM; // R1
                    end
                end
                MAC_WAIT_ARM: begin
                    if (!arm_en) begin
                        state <= MAC_IDLE;
                    end else if (start_edge) begin // R1
                        cnt <= '0;
                        state <= (start_dly == '0) ? MAC_RUN : MAC_DELAY;
                    end
                end
                MAC_DELAY: begin
                    if (tick) begin
                        cnt <= cnt + STEPS_PER_CLK; // R14
                    end
                    if (cnt + STEPS_PER_CLK + EARLY >= start_dly) begin // R13
                        state <= MAC_RUN; // R4
                    end
                end
                MAC_RUN: begin
                    if (stop_en && stop_edge) begin // R8
                        cnt <= '0;
                        if (func == FN_TOTALIZE && stop_dly != '0) begin // R10
                            state <= MAC_STOP_DLY; // R9
                        end else begin
                            state <= MAC_DONE;
                        end
                    end else if (sample_done) begin
                        first_done <= 1'b1; // R5
                        state <= MAC_IDLE;
                    end
                end
                MAC_STOP_DLY: begin
                    if (tick) begin
                        cnt <= cnt + STEPS_PER_CLK;
                    end
                    if (cnt + STEPS_PER_CLK >= stop_dly) begin // R9
                        state <= MAC_DONE;
                    end
                end
                MAC_DONE: state <= MAC_DONE;
                default: state <= MAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_enable <= 1'b0;
            burst_self_sync <= 1'b0;
            stop_trig_block <= 1'b0;
            config_error <= 1'b0;
        end else begin
            meas_enable <= !restart && (state == MAC_RUN || state == MAC_STOP_DLY); // R14
            burst_self_sync <= (func == FN_BURST) && !ctrl[CTRL_ARM_EN]; // R11
            stop_trig_block <= (func == FN_TINTERVAL) && stop_en && stop_lvl; // R12
            config_error <= (ctrl[CTRL_ARM_EN] && !start_ok) || (ctrl[CTRL_STOP_EN] && !stop_ok)
                || (stop_dly != '0 && func != FN_TOTALIZE); // R6 R7 R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_no_run_unarmed;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_WAIT_ARM && !start_edge && arm_en && !restart) |=> state != MAC_RUN;
    endproperty
    a_no_run_unarmed: assert property (p_no_run_unarmed) else $error("Run without arm edge"); // R1

    property p_reject_start;
        @(posedge pclk) disable iff (!presetn)
        ((func == FN_BURST || func == FN_RATIO || func == FN_VOLT) && !$changed(ctrl))
            |-> state != MAC_WAIT_ARM;
    endproperty
    a_reject_start: assert property (p_reject_start) else $error("Start arm not refused"); // R6

    property p_reject_stop;
        @(posedge pclk) disable iff (!presetn)
        (func == FN_RISEFALL && state == MAC_RUN && stop_edge && !restart)
            |=> state != MAC_DONE && state != MAC_STOP_DLY;
    endproperty
    a_reject_stop: assert property (p_reject_stop) else $error("Stop arm not refused"); // R7

    property p_stop_ends;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_RUN && stop_en && stop_edge && func != FN_TOTALIZE && !restart)
            |=> state == MAC_DONE ##1 !meas_enable;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("Stop edge ignored"); // R8

    property p_stop_dly_only_tot;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_STOP_DLY && $changed(state)) |-> $past(func) == FN_TOTALIZE;
    endproperty
    a_stop_dly_only_tot: assert property (p_stop_dly_only_tot) else $error("Bad stop delay"); // R10

    property p_hold_off;
        @(posedge pclk) disable iff (!presetn)
        (func == FN_TINTERVAL && stop_en && stop_lvl) |=> stop_trig_block || $changed(ctrl);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("Hold-off missing"); // R12

    property p_restart_clears;
        @(posedge pclk) disable iff (!presetn)
        restart |=> !meas_enable && state == MAC_IDLE && !first_done;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("Restart no clear"); // R14

    property p_delay_min;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_WAIT_ARM && start_edge && arm_en && start_dly != '0 && !restart)
            |=> state == MAC_DELAY;
    endproperty
    a_delay_min: assert property (p_delay_min) else $error("Delay skipped"); // R4

    property p_burst_mode;
        @(posedge pclk) disable iff (!presetn)
        (func == FN_BURST && ctrl[CTRL_ARM_EN]) |=> !burst_self_sync || $changed(ctrl);
    endproperty
    a_burst_mode: assert property (p_burst_mode) else $error("Armed burst self sync"); // R11

    property p_arm_waits;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_IDLE && arm_en && !first_done && !restart) |=> state == MAC_WAIT_ARM;
    endproperty
    a_arm_waits: assert property (p_arm_waits) else $error("Armed start not waiting"); // R1

    property p_first_only;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_IDLE && first_done && !restart) |=> state == MAC_RUN;
    endproperty
    a_first_only: assert property (p_first_only) else $error("Later sample waited"); // R5

    property p_no_dly_start;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_WAIT_ARM && arm_en && start_edge && start_dly == '0 && !restart)
            |=> state == MAC_RUN;
    endproperty
    a_no_dly_start: assert property (p_no_dly_start) else $error("Undelayed start late"); // R4

    property p_stop_dly_runs;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_STOP_DLY && !restart) |=> meas_enable;
    endproperty
    a_stop_dly_runs: assert property (p_stop_dly_runs) else $error("Stop delay not run"); // R9

    property p_dly_bound;
        @(posedge pclk) disable iff (!presetn)
        (state == MAC_DELAY && cnt >= start_dly && !restart) |=> state == MAC_RUN;
    endproperty
    a_dly_bound: assert property (p_dly_bound) else $error("Start delay overrun"); // R13

    property p_cfg_err;
        @(posedge pclk) disable iff (!presetn)
        (stop_dly != '0 && func != FN_TOTALIZE) |=> config_error;
    endproperty
    a_cfg_err: assert property (p_cfg_err) else $error("Stop delay not flagged"); // R10
endmodule : mac_arming
`default_nettype wire

// *** logic/mac_pkg.sv ***
package mac_pkg;
    // Arming source codes
    localparam logic [1:0] SRC_A = 2'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_E = 2'h2;
    // Measurement function codes
    localparam logic [3:0] FN_FREQ = 4'h0;
    localparam logic [3:0] FN_BURST = 4'h1;
    localparam logic [3:0] FN_RATIO = 4'h2;
    localparam logic [3:0] FN_VOLT = 4'h3;
    localparam logic [3:0] FN_RISEFALL = 4'h4;
    localparam logic [3:0] FN_TOTALIZE = 4'h5;
    localparam logic [3:0] FN_TINTERVAL = 4'h6;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_START_DLY = 12'h004;
    localparam logic [11:0] OFS_STOP_DLY = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_CMD = 12'h010;
    // Control field positions
    localparam int CTRL_ARM_EN = 0;
    localparam int CTRL_STOP_EN = 1;
    localparam int CTRL_START_FALL = 2;
    localparam int CTRL_STOP_FALL = 3;
    localparam int CTRL_START_SRC = 4;
    localparam int CTRL_STOP_SRC = 6;
    localparam int CTRL_FUNC = 8;
    localparam int CMD_RESTART = 0;
    localparam int CMD_SAMPLE_DONE = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DLY_STEP_NS = 10;
    localparam int DLY_MIN_NS = 20;
    localparam longint DLY_MAX_NS = 64'd2000000000;
    localparam int EARLY_ACCEPT_NS = 60;
    localparam int LATE_GUARD_NS = 40;
    localparam logic [27:0] DLY_MIN_STEPS = 28'(DLY_MIN_NS / DLY_STEP_NS);
    localparam logic [27:0] DLY_MAX_STEPS = 28'(DLY_MAX_NS / DLY_STEP_NS);
    localparam logic [27:0] EARLY_STEPS = 28'(EARLY_ACCEPT_NS / DLY_STEP_NS);
    typedef enum logic [2:0] {
        MAC_IDLE, MAC_WAIT_ARM, MAC_DELAY, MAC_RUN, MAC_STOP_DLY, MAC_DONE
    } mac_state_t;
endpackage : mac_pkg

// *** logic/mac_edge_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_edge_sel
    import mac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_a,
    input wire logic in_b,
    input wire logic in_e,
    input wire logic [1:0] src,
    input wire logic falling,
    output logic level,
    output logic edge_seen
);
    logic sel;
    logic prev;
    logic primed;
    always_comb begin
        case (src)
            SRC_A: sel = in_a;
            SRC_B: sel = in_b;
            SRC_E: sel = in_e;
            default: sel = in_e;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            primed <= 1'b0;
        end else begin
            prev <= sel;
            primed <= 1'b1;
        end
    end
    assign level = falling ? !sel : sel;
    // No edge until prev holds a real sample, so a pin idling high fakes none
    assign edge_seen = primed && (falling ? (prev && !sel) : (!prev && sel));

    property p_edge_polarity;
        @(posedge pclk) disable iff (!presetn)
        (edge_seen && $stable(falling)) |-> level && !$past(level);
    endproperty
    a_edge_polarity: assert property (p_edge_polarity) else $error("Edge of wrong polarity"); // R3
endmodule : mac_edge_sel
`default_nettype wire

// *** logic/mac_tick_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_tick_div #(
    parameter int STEPS_PER_CLK = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    output logic tick
);
    // Clock slower than step: each clock covers several steps, so the
    // pulse stands every clock and drops only for the clock after a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            tick <= !clear;
        end
    end
endmodule : mac_tick_div
`default_nettype wire

// *** dv/mac_sync_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_sync_src (
    input wire logic pclk,
    output logic in_a,
    output logic in_b,
    output logic in_e
);
    logic [2:0] lvl = 3'h0;
    assign in_a = lvl[0];
    assign in_b = lvl[1];
    assign in_e = lvl[2];
    // Level held three clocks so a slow edge detector still sees it
    task automatic drive(input int ch, input logic v);
        @(posedge pclk);
        lvl[ch] <= v;
        repeat (3) @(posedge pclk);
    endtask : drive
    task automatic idle(input logic v);
        @(posedge pclk);
        lvl <= {3{v}};
        repeat (3) @(posedge pclk);
    endtask : idle
endmodule : mac_sync_src
`default_nettype wire

// *** dv/measurement_arming_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module measurement_arming_control_tb;
    import mac_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, in_a, in_b, in_e, meas_enable, burst_self_sync, stop_trig_block;
    logic config_error;
    int miscompares = 0;
    int n_compared = 0;
    always #50 pclk = ~pclk;
    mac_sync_src src_u (.pclk(pclk), .in_a(in_a), .in_b(in_b), .in_e(in_e));
    mac_arming dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_a(in_a), .in_b(in_b), .in_e(in_e), .meas_enable(meas_enable),
        .burst_self_sync(burst_self_sync), .stop_trig_block(stop_trig_block),
        .config_error(config_error));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [31:0] b(input logic x);
        return {31'h0, x};
    endfunction : b
    function automatic logic [31:0] ctl(input logic arm, input logic stp, input logic sf,
        input logic pf, input logic [1:0] ss, input logic [1:0] ps, input logic [3:0] fn);
        return {20'h0, fn, ps, ss, pf, sf, stp, arm};
    endfunction : ctl
    ////////////////////////////////////////////////////////////////////////////////
    // Idle edge after each transfer so psel never changes twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a stalled access
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic cfg(input logic [31:0] c);
        wr(OFS_CTRL, c);
        wr(OFS_CMD, 32'h0000_0001);
        repeat (3) @(posedge pclk);
    endtask : cfg
    task automatic wait_me(input logic v, input int lim, output int n);
        n = 0;
        while (meas_enable !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_me
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, OFS_CTRL, 32'h0, q, e);
        chk("ctrl_reset", CTRL_RESET, q);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped_err", 32'h1, b(e));
        chk("unmapped_data", 32'h0, q);
        wr(OFS_CTRL, 32'h0000_0695);
        apb(1'b0, OFS_CTRL, 32'h0, q, e);
        chk("ctrl_back", 32'h0000_0695, q);
    endtask : t_regs
    task automatic t_arm();
        int n;
        for (int s = 0; s < 3; s++) begin
            for (int f = 0; f < 2; f++) begin
                src_u.idle(f[0]);
                cfg(ctl(1'b1, 1'b0, f[0], 1'b0, s[1:0], SRC_A, FN_FREQ));
                chk("wait_arm", 32'h0, b(meas_enable));
                src_u.drive((s + 1) % 3, ~f[0]);
                chk("other_src", 32'h0, b(meas_enable));
                src_u.drive(s, ~f[0]);
                wait_me(1'b1, 10, n);
                chk("armed_run", 32'h1, b(meas_enable));
            end
        end
    endtask : t_arm
    task automatic t_stop(input logic [3:0] fn, input logic [31:0] sd);
        int n;
        logic [31:0] q;
        logic e;
        src_u.idle(1'b0);
        src_u.drive(0, 1'b1);
        wr(OFS_STOP_DLY, sd);
        cfg(ctl(1'b1, 1'b1, 1'b0, 1'b1, SRC_E, SRC_A, fn));
        chk("cfg_err", b(sd != 0 && fn != FN_TOTALIZE), b(config_error));
        src_u.drive(2, 1'b1);
        wait_me(1'b1, 10, n);
        chk("start", 32'h1, b(meas_enable));
        src_u.drive(0, 1'b0);
        wait_me(1'b0, 60, n);
        chk("stopped", 32'h0, b(meas_enable));
        chk("stop_len", 32'h1, b(sd != 0 && fn == FN_TOTALIZE ? (n >= 20 && n <= 40) : n <= 5));
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        chk("state_done", 32'h5, {29'h0, q[2:0]});
        wr(OFS_STOP_DLY, 32'h0);
    endtask : t_stop
    task automatic t_func();
        logic [3:0] fn;
        logic bad;
        for (int i = 0; i < 7; i++) begin
            fn = i[3:0];
            bad = (fn == FN_BURST || fn == FN_RATIO || fn == FN_VOLT);
            cfg(ctl(1'b0, 1'b0, 1'b0, 1'b0, SRC_E, SRC_E, fn));
            chk("self_sync", b(fn == FN_BURST), b(burst_self_sync));
            cfg(ctl(1'b1, 1'b0, 1'b0, 1'b0, SRC_E, SRC_E, fn));
            chk("start_refuse", b(bad), b(config_error));
            chk("armed_sync", 32'h0, b(burst_self_sync));
            cfg(ctl(1'b1, 1'b1, 1'b0, 1'b0, SRC_E, SRC_B, fn));
            chk("stop_refuse", b(bad || fn == FN_RISEFALL), b(config_error));
        end
        wr(OFS_STOP_DLY, 32'h0000_012C);
        cfg(ctl(1'b1, 1'b1, 1'b0, 1'b0, SRC_E, SRC_B, FN_FREQ));
        chk("stop_dly_refuse", 32'h1, b(config_error));
        wr(OFS_STOP_DLY, 32'h0);
    endtask : t_func
    task automatic t_hold();
        for (int f = 0; f < 2; f++) begin
            src_u.idle(f[0]);
            cfg(ctl(1'b1, 1'b1, 1'b0, f[0], SRC_A, SRC_E, FN_TINTERVAL));
            chk("hold_off", 32'h0, b(stop_trig_block));
            src_u.drive(2, ~f[0]);
            chk("hold_on", 32'h1, b(stop_trig_block));
        end
    endtask : t_hold
    task automatic t_delay();
        int n;
        src_u.idle(1'b0);
        wr(OFS_START_DLY, 32'h0000_00C8);
        cfg(ctl(1'b1, 1'b0, 1'b0, 1'b0, SRC_E, SRC_E, FN_FREQ));
        src_u.drive(2, 1'b1);
        wait_me(1'b1, 40, n);
        chk("dly_len", 32'h1, b(n >= 12 && n <= 24));
        src_u.idle(1'b0);
        wr(OFS_CMD, 32'h0000_0001);
        src_u.drive(2, 1'b1);
        wr(OFS_CMD, 32'h0000_0001);
        wait_me(1'b1, 30, n);
        chk("restart_clr", 32'h0, b(meas_enable));
        wr(OFS_START_DLY, 32'h0);
    endtask : t_delay
    task automatic t_avg();
        int n;
        logic [31:0] q;
        logic e;
        src_u.idle(1'b0);
        cfg(ctl(1'b1, 1'b0, 1'b0, 1'b0, SRC_E, SRC_E, FN_FREQ));
        src_u.drive(2, 1'b1);
        wr(OFS_CMD, 32'h0000_0002);
        wait_me(1'b1, 10, n);
        chk("next_sample", 32'h1, b(meas_enable));
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        chk("first_done", 32'h1, b(q[5]));
    endtask : t_avg
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_arm();
        t_stop(FN_TOTALIZE, 32'h0000_012C);
        t_stop(FN_FREQ, 32'h0000_012C);
        t_func();
        t_hold();
        t_delay();
        t_avg();
        tally_and_finish();
    end
    // Run needs about 600 clocks; the 30000-clock limit, some fifty times that, flags a hang
    initial begin
        #3000000;
        miscompares++;
        tally_and_finish();
    end
endmodule : measurement_arming_control_tb
`default_nettype wire
